// File: inc/status_shift_pkg.sv
// Constants for the status and shift control unit.
// Assumes an APB master on pclk and a bit-slice ALU on the same clock.
package status_shift_pkg;
  // APB register byte offsets
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  // Control register fields
  localparam int          CTRL_OVR_BIT  = 0;
  localparam int          CTRL_OP_LSB   = 16;
  localparam int          OP_WIDTH      = 13;
  // Status register fields
  localparam int          STAT_MICRO    = 0;
  localparam int          STAT_MACHINE  = 4;
  localparam int          STAT_COND     = 8;
  localparam int          STAT_CARRY    = 9;
  // Flag vector layout
  localparam int          FLAG_Z        = 0;
  localparam int          FLAG_C        = 1;
  localparam int          FLAG_N        = 2;
  localparam int          FLAG_V        = 3;
  localparam logic [3:0]  FLAGS_RESET   = 4'h0;
  // Flag operation codes, two octal digits on op bits 5..0
  localparam logic [5:0]  OP_XFER       = 6'o00;
  localparam logic [5:0]  OP_SET        = 6'o01;
  localparam logic [5:0]  OP_SWAP       = 6'o02;
  localparam logic [5:0]  OP_RESET      = 6'o03;
  localparam logic [5:0]  OP_CPL_A      = 6'o04;
  localparam logic [5:0]  OP_CPL_B      = 6'o05;
  localparam logic [5:0]  OP_RETAIN_A   = 6'o06;
  localparam logic [5:0]  OP_RETAIN_B   = 6'o07;
  localparam logic [2:0]  OP_BIT_GROUP  = 3'o1;
  localparam logic [2:0]  CINV_LOW      = 3'o0;
  // Carry-in sources on {op12, op11, op5}
  localparam logic [2:0]  CIN_ZERO_A    = 3'h0;
  localparam logic [2:0]  CIN_ZERO_B    = 3'h1;
  localparam logic [2:0]  CIN_ONE       = 3'h2;
  localparam logic [2:0]  CIN_ALT       = 3'h3;
  localparam logic [2:0]  CIN_MICRO     = 3'h4;
  localparam logic [2:0]  CIN_MICRO_N   = 3'h5;
  localparam logic [2:0]  CIN_MACH      = 3'h6;
  localparam logic [2:0]  CIN_MACH_N    = 3'h7;
  // Condition source on op bits 5..4
  localparam logic [1:0]  CSRC_MICRO    = 2'h0;
  localparam logic [1:0]  CSRC_MACHINE  = 2'h1;
  // Shift fill selections
  localparam logic [1:0]  FILL_ZERO     = 2'h0;
  localparam logic [1:0]  FILL_ONE      = 2'h1;
  localparam logic [1:0]  FILL_ROTATE   = 2'h2;
  localparam logic [1:0]  FILL_LINK     = 2'h3;
endpackage

// File: verilog/status_shift_control_unit.sv
// Status flags, condition test, shift linkage and carry-in selection for a slice array.
// Assumes the ALU slices and sequencer run on pclk; their signals need no synchroniser.
//
// What this block does
// - Carry-in output picks one of seven sources
// - Shift linkage offers thirty-two shift and rotate modes
// - Condition test picks one of sixteen conditions
// - Test reads micro, machine or live flags
// - Tests give true, inverted flags and combinations
// - Two four-bit flag registers, bitwise manipulable
// - Instructions set or clear single flag bits
// - Machine bits change when overall enable low
// - Machine flags hold while overall enable high
// - Per-bit enable low lets bit update
// - Micro enable high freezes micro flags
// - Status bus reads flags, loads machine flags
// - Status bus drives only while its enable low
// - Condition output drives only while enable low
// - Shift links drive only while enable low
// - Four tri-state muxes serve both path ends
// - Alternate carry routable to the carry output
// - Flag registers change on the rising pclk edge, or at once when presetn falls
// - Everything else is combinational apart from ctrl_q and prdata
// - Six low operation lines select flag operations
// - Codes 06, 07 load micro flags with overflow retain
// - Machine flags support set, single-bit clear, complement; code 03 loads micro flags
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module status_shift_control_unit
  import status_shift_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Operation and enables
  input  wire logic [12:0]   op_lines,
  input  wire logic          micro_flags_hold_n,
  input  wire logic          machine_flags_hold_n,
  input  wire logic          zero_bit_update_n,
  input  wire logic          carry_bit_update_n,
  input  wire logic          sign_bit_update_n,
  input  wire logic          overflow_bit_update_n,
  // Live ALU status
  input  wire logic          zero_flag_source,
  input  wire logic          carry_flag_source,
  input  wire logic          sign_flag_source,
  input  wire logic          overflow_flag_source,
  input  wire logic          alt_carry_source,
  // Status bus, bits {overflow, sign, carry, zero}
  input  wire logic [3:0]    status_bus_i,
  output logic [3:0]         status_bus_o,
  output logic               status_bus_oe,
  input  wire logic          status_bus_drive_n,
  // Condition test
  output logic               cond_result,
  output logic               cond_result_oe,
  input  wire logic          cond_out_drive_n,
  // Shift links
  input  wire logic          ram_shift_low_link_i,
  output logic               ram_shift_low_link_o,
  output logic               ram_shift_low_link_oe,
  input  wire logic          ram_shift_high_link_i,
  output logic               ram_shift_high_link_o,
  output logic               ram_shift_high_link_oe,
  input  wire logic          aux_shift_low_link_i,
  output logic               aux_shift_low_link_o,
  output logic               aux_shift_low_link_oe,
  input  wire logic          aux_shift_high_link_i,
  output logic               aux_shift_high_link_o,
  output logic               aux_shift_high_link_oe,
  input  wire logic          shift_drive_n,
  // Carry feed to the least significant slice
  output logic               alu_carry_feed
);

  logic [31:0] ctrl_q;
  logic [31:0] rdata_d;
  logic [3:0]  micro_q;
  logic [3:0]  micro_d;
  logic [3:0]  machine_q;
  logic [3:0]  machine_d;
  logic [3:0]  live;
  logic [3:0]  bit_update_n;
  logic [3:0]  test_src;
  logic [12:0] op;
  logic [5:0]  fop;
  logic [4:0]  shift_mode;
  logic [2:0]  cin_sel;
  logic        cond_raw;
  logic        ram_fill;
  logic        aux_fill;
  logic        apb_hit;

  assign live         = {overflow_flag_source, sign_flag_source, carry_flag_source, zero_flag_source};
  assign bit_update_n = {overflow_bit_update_n, sign_bit_update_n, carry_bit_update_n, zero_bit_update_n};

  // Software may take over the operation lines for bring-up and diagnosis
  assign op  = ctrl_q[CTRL_OVR_BIT] ? ctrl_q[CTRL_OP_LSB +: OP_WIDTH] : op_lines;
  assign fop = op[5:0];

  // APB slave: zero wait states, unmapped offsets answer with an error
  assign apb_hit = (paddr == CTRL_OFS) || (paddr == STATUS_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !apb_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= CTRL_RESET;
    else if (psel && penable && pwrite && paddr == CTRL_OFS)
      ctrl_q <= pwdata;
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (paddr == CTRL_OFS)
      rdata_d = ctrl_q;
    else if (paddr == STATUS_OFS)
    begin
      rdata_d[STAT_MICRO +: 4]   = micro_q;
      rdata_d[STAT_MACHINE +: 4] = machine_q;
      rdata_d[STAT_COND]         = cond_raw;
      rdata_d[STAT_CARRY]        = alu_carry_feed;
    end
  end

  // Read data is captured in the setup cycle, so it leaves a flip-flop with no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rdata_d;
  end

  // Micro flag next value
  always_comb
  begin
    micro_d = live;
    case (fop)
      OP_XFER, OP_SWAP:
        micro_d = machine_q;
      OP_SET:
        micro_d = 4'hf;
      OP_RESET:
        micro_d = 4'h0;
      OP_RETAIN_A, OP_RETAIN_B:
        micro_d = {overflow_flag_source | micro_q[FLAG_V], live[2:0]};
      default:
      begin
        if (fop[5:3] == OP_BIT_GROUP)
        begin
          micro_d = micro_q;
          micro_d[fop[2:1]] = fop[0];
        end
        else if (fop[5:3] != CINV_LOW && fop[3] && fop[2:1] == 2'b00)
          micro_d[FLAG_C] = ~carry_flag_source;
      end
    endcase
  end

  // Machine flag next value
  always_comb
  begin
    machine_d = live;
    case (fop)
      OP_XFER:
        machine_d = status_bus_i;
      OP_SET:
        machine_d = 4'hf;
      OP_SWAP, OP_RESET:
        machine_d = micro_q;
      OP_CPL_A, OP_CPL_B:
        machine_d = ~machine_q;
      default:
      begin
        if (fop[5:3] == OP_BIT_GROUP)
        begin
          machine_d = machine_q;
          machine_d[fop[2:1]] = fop[0];
        end
      end
    endcase
  end

  // The flag registers are clocked like ctrl_q and prdata; the reset gives them a known start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      micro_q <= FLAGS_RESET;
    else if (!micro_flags_hold_n)
      micro_q <= micro_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      machine_q <= FLAGS_RESET;
    else
      for (int i = 0; i < 4; i++)
        if (!machine_flags_hold_n && !bit_update_n[i])
          machine_q[i] <= machine_d[i];
  end

  // Condition test, combinational
  always_comb
  begin
    case (op[5:4])
      CSRC_MICRO:   test_src = micro_q;
      CSRC_MACHINE: test_src = machine_q;
      default:      test_src = live;
    endcase
  end

  always_comb
  begin
    case (op[3:1])
      3'd0:    cond_raw = test_src[FLAG_Z];
      3'd1:    cond_raw = test_src[FLAG_C];
      3'd2:    cond_raw = test_src[FLAG_N];
      3'd3:    cond_raw = test_src[FLAG_V];
      3'd4:    cond_raw = test_src[FLAG_N] ^ test_src[FLAG_V];
      3'd5:    cond_raw = (test_src[FLAG_N] ^ test_src[FLAG_V]) | test_src[FLAG_Z];
      3'd6:    cond_raw = test_src[FLAG_C] & ~test_src[FLAG_Z];
      default: cond_raw = test_src[FLAG_N] | test_src[FLAG_Z];
    endcase
  end

  // Odd codes give the inverse of each test
  assign cond_result    = cond_raw ^ op[0];
  assign cond_result_oe = !cond_out_drive_n;

  // Status bus shows micro flags when op bit 4 is set, else machine flags
  assign status_bus_o  = op[4] ? micro_q : machine_q;
  assign status_bus_oe = !status_bus_drive_n;

  // Shift linkage: mode bit 4 is direction, then ram fill and aux fill selects
  assign shift_mode = op[10:6];

  always_comb
  begin
    case (shift_mode[3:2])
      FILL_ZERO:   ram_fill = 1'b0;
      FILL_ONE:    ram_fill = 1'b1;
      FILL_ROTATE: ram_fill = shift_mode[4] ? ram_shift_high_link_i : ram_shift_low_link_i;
      default:     ram_fill = machine_q[FLAG_C];
    endcase
    case (shift_mode[1:0])
      FILL_ZERO:   aux_fill = 1'b0;
      FILL_ONE:    aux_fill = 1'b1;
      FILL_ROTATE: aux_fill = shift_mode[4] ? aux_shift_high_link_i : aux_shift_low_link_i;
      default:     aux_fill = shift_mode[4] ? ram_shift_high_link_i : ram_shift_low_link_i;
    endcase
  end

  // Up shifts feed the low ends, down shifts the high ends; the other end is read
  assign ram_shift_low_link_o   = ram_fill;
  assign aux_shift_low_link_o   = aux_fill;
  assign ram_shift_high_link_o  = ram_fill;
  assign aux_shift_high_link_o  = aux_fill;
  assign ram_shift_low_link_oe  = !shift_drive_n && shift_mode[4];
  assign aux_shift_low_link_oe  = !shift_drive_n && shift_mode[4];
  assign ram_shift_high_link_oe = !shift_drive_n && !shift_mode[4];
  assign aux_shift_high_link_oe = !shift_drive_n && !shift_mode[4];

  // Carry-in selection, combinational
  assign cin_sel = {op[12], op[11], op[5]};

  always_comb
  begin
    case (cin_sel)
      CIN_ZERO_A, CIN_ZERO_B: alu_carry_feed = 1'b0;
      CIN_ONE:                alu_carry_feed = 1'b1;
      CIN_ALT:                alu_carry_feed = alt_carry_source;
      CIN_MICRO:              alu_carry_feed = micro_q[FLAG_C];
      CIN_MICRO_N:            alu_carry_feed = ~micro_q[FLAG_C];
      CIN_MACH:               alu_carry_feed = machine_q[FLAG_C];
      default:                alu_carry_feed = ~machine_q[FLAG_C];
    endcase
  end

  machine_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    machine_flags_hold_n |=> $stable(machine_q))
    else $error("machine flags changed while held");

  zero_bit_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    zero_bit_update_n |=> machine_q[FLAG_Z] == $past(machine_q[FLAG_Z]))
    else $error("machine zero bit changed while its enable was high");

  micro_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    micro_flags_hold_n |=> $stable(micro_q))
    else $error("micro flags changed while held");

  overflow_retain_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!micro_flags_hold_n && fop[5:1] == 5'b00011)
      |=> micro_q[FLAG_V] == ($past(overflow_flag_source) | $past(micro_q[FLAG_V])))
    else $error("overflow retain load wrong");

  bit_op_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!micro_flags_hold_n && fop[5:3] == OP_BIT_GROUP) |=> micro_q[$past(fop[2:1])] == $past(fop[0]))
    else $error("micro single bit operation wrong");

  machine_cpl_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!machine_flags_hold_n && bit_update_n == 4'h0 && fop[5:1] == 5'b00010)
      |=> machine_q == ~$past(machine_q))
    else $error("machine complement wrong");

  cond_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    cond_result_oe != cond_out_drive_n)
    else $error("condition output enable wrong");

  status_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_bus_drive_n |-> !status_bus_oe)
    else $error("status bus driven while disabled");

  shift_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    shift_drive_n |-> !(ram_shift_low_link_oe | ram_shift_high_link_oe
                        | aux_shift_low_link_oe | aux_shift_high_link_oe))
    else $error("shift link driven while disabled");

  alt_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
    cin_sel == CIN_ALT |-> alu_carry_feed == alt_carry_source)
    else $error("alternate carry not routed");

  machine_bit_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!machine_flags_hold_n && !zero_bit_update_n && fop == OP_SET) |=> machine_q[FLAG_Z])
    else $error("machine zero bit not set");

  carry_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    cin_sel == CIN_ONE |-> alu_carry_feed)
    else $error("carry feed not forced high");

  read_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == STATUS_OFS) |=> prdata[STAT_MACHINE +: 4] == $past(machine_q))
    else $error("status read data wrong");

endmodule
`default_nettype wire

// File: dv/alu_slice_model.sv
// Behavioural stand-in for the slice array on the far side of the status unit.
// Assumes the bench sets the reported flags and the values the slices put on their shift ends.
`timescale 1ns/1ns
`default_nettype none
module alu_slice_model (
  // Reported status, bits {overflow, sign, carry, zero}
  input  wire logic [3:0] result_flags,
  input  wire logic       alt_carry,
  output logic            zero_flag_source,
  output logic            carry_flag_source,
  output logic            sign_flag_source,
  output logic            overflow_flag_source,
  output logic            alt_carry_source,
  // Shift ends, bits {aux high, aux low, ram high, ram low}
  input  wire logic [3:0] slice_ends,
  input  wire logic [3:0] link_o,
  input  wire logic [3:0] link_oe,
  output logic [3:0]      link_i
);
  assign {overflow_flag_source, sign_flag_source, carry_flag_source, zero_flag_source} = result_flags;
  assign alt_carry_source = alt_carry;
  // Slices drive an end only where the unit lets go, so the wire never sees contention
  assign link_i = (link_oe & link_o) | (~link_oe & slice_ends);
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the status and shift control unit.
// Assumes the unit answers APB with no wait states and is fed by the slice model.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import status_shift_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [12:0] op = 13'h0000;
  logic        uhold_n = 1'b1;
  logic        mhold_n = 1'b1;
  logic [3:0]  en_n = 4'hf;
  logic        drive_bus_n = 1'b1;
  logic        drive_ct_n = 1'b0;
  logic        drive_sh_n = 1'b0;
  logic [3:0]  live = 4'h5;
  logic [3:0]  bus_drv = 4'ha;
  logic        alt = 1'b1;
  logic [3:0]  bus_o;
  logic [3:0]  bus_i;
  logic        bus_oe;
  logic        ct;
  logic        ct_oe;
  logic        cfeed;
  logic        zf;
  logic        cf;
  logic        nf;
  logic        vf;
  logic        altc;
  logic [3:0]  lk_i;
  logic [3:0]  lk_o;
  logic [3:0]  lk_oe;
  logic [3:0]  um = 4'h0;
  logic [3:0]  mm = 4'h0;
  logic [7:0]  cin;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #50 pclk = ~pclk;
  // Bus pins resolve to the unit while it drives, else to the bench's save value
  assign bus_i = bus_oe ? bus_o : bus_drv;

  status_shift_control_unit uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_lines(op), .micro_flags_hold_n(uhold_n), .machine_flags_hold_n(mhold_n),
    .zero_bit_update_n(en_n[0]), .carry_bit_update_n(en_n[1]), .sign_bit_update_n(en_n[2]),
    .overflow_bit_update_n(en_n[3]), .zero_flag_source(zf), .carry_flag_source(cf),
    .sign_flag_source(nf), .overflow_flag_source(vf), .alt_carry_source(altc),
    .status_bus_i(bus_i), .status_bus_o(bus_o), .status_bus_oe(bus_oe),
    .status_bus_drive_n(drive_bus_n), .cond_result(ct), .cond_result_oe(ct_oe),
    .cond_out_drive_n(drive_ct_n), .ram_shift_low_link_i(lk_i[0]), .ram_shift_low_link_o(lk_o[0]),
    .ram_shift_low_link_oe(lk_oe[0]), .ram_shift_high_link_i(lk_i[1]), .ram_shift_high_link_o(lk_o[1]),
    .ram_shift_high_link_oe(lk_oe[1]), .aux_shift_low_link_i(lk_i[2]), .aux_shift_low_link_o(lk_o[2]),
    .aux_shift_low_link_oe(lk_oe[2]), .aux_shift_high_link_i(lk_i[3]), .aux_shift_high_link_o(lk_o[3]),
    .aux_shift_high_link_oe(lk_oe[3]), .shift_drive_n(drive_sh_n), .alu_carry_feed(cfeed)
  );

  alu_slice_model partner (
    .result_flags(live), .alt_carry(alt), .zero_flag_source(zf), .carry_flag_source(cf),
    .sign_flag_source(nf), .overflow_flag_source(vf), .alt_carry_source(altc),
    .slice_ends(4'h5), .link_o(lk_o), .link_oe(lk_oe), .link_i(lk_i)
  );

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One enabled flag edge, then both registers frozen again
  task automatic step(input logic [12:0] o, input logic uh, input logic mh, input logic [3:0] en);
    @(posedge pclk);
    op <= o;
    uhold_n <= uh;
    mhold_n <= mh;
    en_n <= en;
    @(posedge pclk);
    uhold_n <= 1'b1;
    mhold_n <= 1'b1;
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
  endtask

  // Combinational paths are sampled mid-cycle, well clear of the edge
  task automatic apply(input logic [12:0] o, input logic [2:0] dn);
    @(posedge pclk);
    op <= o;
    {drive_bus_n, drive_ct_n, drive_sh_n} <= dn;
    #50;
  endtask

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rd[7:0], {FLAGS_RESET, FLAGS_RESET});
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rd, CTRL_RESET);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    for (int j = 0; j < 8; j++)
    begin
      step({7'h00, OP_BIT_GROUP, j[2:0]}, 1'b0, 1'b1, 4'hf);
      um[j / 2] = j[0];
      chk(rd[7:0], {mm, um});
    end
    step({7'h00, OP_RESET}, 1'b1, 1'b1, 4'h0);
    chk(rd[7:0], {mm, um});
    step({7'h00, OP_RETAIN_A}, 1'b0, 1'b1, 4'hf);
    um = {um[3] | live[3], live[2:0]};
    chk(rd[7:0], {mm, um});
    step({7'h00, OP_SET}, 1'b1, 1'b0, 4'he);
    mm = 4'h1;
    chk(rd[7:0], {mm, um});
    step({7'h00, OP_CPL_A}, 1'b1, 1'b0, 4'h0);
    mm = ~mm;
    chk(rd[7:0], {mm, um});
    step({7'h00, OP_XFER}, 1'b1, 1'b0, 4'h0);
    mm = bus_drv;
    chk(rd[7:0], {mm, um});
    apply(13'h0010, 3'b000);
    chk({bus_oe, bus_i}, {1'b1, um});
    apply(13'h0000, 3'b000);
    chk({bus_oe, bus_i}, {1'b1, mm});
    apply(13'h0000, 3'b100);
    chk(bus_oe, 1'b0);
    // Live flags Z=1 C=0 N=1 V=0 give this truth per condition code
    for (int k = 0; k < 16; k++)
    begin
      apply({7'h00, 2'b10, k[3:0]}, 3'b100);
      chk({ct_oe, ct}, {1'b1, 1'((8'hb5 >> (k / 2)) ^ k)});
    end
    apply({7'h00, 2'b00, 4'h0}, 3'b100);
    chk(ct, um[0]);
    apply({7'h00, 2'b01, 4'h3}, 3'b110);
    chk({ct_oe, ct}, {1'b0, ~mm[1]});
    cin = {~mm[1], mm[1], ~um[1], um[1], alt, 3'b100};
    for (int s = 0; s < 8; s++)
    begin
      apply({s[2:1], 5'h00, s[0], 5'h00}, 3'b100);
      chk(cfeed, cin[s]);
    end
    alt <= 1'b0;
    apply({2'b01, 5'h00, 1'b1, 5'h00}, 3'b100);
    chk(cfeed, 1'b0);
    apply({2'b00, 5'h05, 6'o00}, 3'b100);
    chk({lk_oe, lk_o & lk_oe}, 8'haa);
    apply({2'b00, 5'h11, 6'o00}, 3'b100);
    chk({lk_oe, lk_o & lk_oe}, 8'h54);
    apply({2'b00, 5'h0c, 6'o00}, 3'b100);
    chk({lk_oe, lk_o & lk_oe}, {4'ha, 2'b00, mm[1], 1'b0});
    apply({2'b00, 5'h0b, 6'o00}, 3'b100);
    chk({lk_oe, lk_o & lk_oe}, 8'haa);
    apply({2'b00, 5'h1b, 6'o00}, 3'b100);
    chk({lk_oe, lk_o & lk_oe}, 8'h50);
    apply({2'b00, 5'h05, 6'o00}, 3'b101);
    chk(lk_oe, 4'h0);
    apb(1'b1, CTRL_OFS, 32'h0800_0001);
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0800_0001);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rd[9:8], {1'b1, um[FLAG_Z]});
    chk(cfeed, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
